// File: include/can_mode_control_defines.vh
// constants for the can mode control register block
// assumes inclusion by bare name from logic files
`ifndef CAN_MODE_CONTROL_DEFINES_VH
`define CAN_MODE_CONTROL_DEFINES_VH

// =========================================
// register map (byte addresses, word aligned)
`define ADDR_MODE_CTRL 4'h0
`define ADDR_MODE_STAT 4'h4
`define ADDR_WIDTH 4

// =========================================
// field positions in the mode control word
`define BIT_STOP_IN_IDLE 13
`define BIT_ABORT_ALL 12
`define BIT_RESERVED 11
`define REQ_HI 10
`define REQ_LO 8
`define CUR_HI 7
`define CUR_LO 5
`define BIT_CAPTURE 3
`define BIT_WINDOW 0

// =========================================
// status word field positions
`define STAT_IDLE 0
`define STAT_TX_BUSY 1
`define STAT_HALTED 2
`define STAT_PENDING 3

// =========================================
// mode encodings and reset values
`define MODE_NORMAL 3'h0
`define MODE_DISABLE 3'h1
`define MODE_LOOPBACK 3'h2
`define MODE_LISTEN 3'h3
`define MODE_CONFIG 3'h4
`define MODE_LISTEN_ALL 3'h7
`define MODE_RESET 3'h4

// =========================================
// timing
`define IDLE_BITS 11
`define IDLE_CNT_W 4

`endif

// File: logic/can_mode_control.v
// mode control register of a can controller with its mode sequencer
// assumes an avalon-mm master, a one-cycle bit-sample enable from the
// bit timing logic, and a bus level already synchronised to clk
//
// Operation
// - stop-in-idle one halts the controller while the processor idles
// - abort-all signals every tx buffer, self-clears when all aborted
// - mode request field bits 10:8 picks the target operating mode
// - current mode bits 7:5 show mode in effect, never 101 or 110
// - both mode fields reset to configuration, 100
// - capture enable one pulses input-capture trigger per received message
// - window select one maps filter registers, zero maps message buffers
// - unimplemented bits 15:14, 4, 2:1 read zero, writes ignored
// - mode changes only after eleven consecutive recessive bits
// - no config entry during transmit; config registers locked outside config
`timescale 1ns/1ps
`include "can_mode_control_defines.vh"

module can_mode_control #(
  parameter IDLE_BITS = `IDLE_BITS
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // avalon-mm slave
  input wire [`ADDR_WIDTH-1:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output wire waitrequest,
  // protocol engine side
  input wire bitTick,
  input wire busRecessive,
  input wire txBusy,
  input wire txAllAborted,
  input wire rxMessageDone,
  input wire cpuIdle,
  // controls out
  output wire abortAllTx,
  output wire moduleHalt,
  output reg captureTrigger,
  output wire filterWindow,
  output wire [2:0] currentMode,
  output wire configUnlocked
);

  // =========================================
  // register state
  reg stopInIdle_q;
  reg abortAll_q;
  reg [2:0] modeReq_q;
  reg [2:0] curMode_q;
  reg capEn_q;
  reg window_q;
  reg [`IDLE_CNT_W-1:0] idleCnt_q;
  reg ack_q;

  wire busIdle;
  wire wrCtrl;
  wire rdAccess;
  wire modeChange;
  wire reqAllowed;
  wire [15:0] ctrlWord;
  wire [15:0] statWord;

  // one wait state: the ack register answers every request on the first edge
  // read data latch on the first edge so they stand when waitrequest is sampled low;
  // a write lands only on the edge that completes the transfer
  assign waitrequest = (read | write) & ~ack_q;
  assign rdAccess = read & ~ack_q;
  assign wrCtrl = write & ack_q & (address == `ADDR_MODE_CTRL);

  always @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  // =========================================
  // bus idle detection, counted in bit times
  assign busIdle = (idleCnt_q >= IDLE_BITS[`IDLE_CNT_W-1:0]);

  always @(posedge clk) begin
    if (reset) begin
      idleCnt_q <= {`IDLE_CNT_W{1'b0}};
    end else if (bitTick) begin
      if (!busRecessive) begin
        idleCnt_q <= {`IDLE_CNT_W{1'b0}};
      end else if (!busIdle) begin
        idleCnt_q <= idleCnt_q + 1'b1;
      end
    end
  end

  // =========================================
  // mode sequencer
  // reserved requests are held off rather than reported, so current mode stays legal
  assign reqAllowed = (modeReq_q != 3'h5) && (modeReq_q != 3'h6);
  assign modeChange = (modeReq_q != curMode_q) && reqAllowed && busIdle
    && !((modeReq_q == `MODE_CONFIG) && txBusy);

  always @(posedge clk) begin
    if (reset) begin
      curMode_q <= `MODE_RESET;
    end else if (modeChange) begin
      curMode_q <= modeReq_q;
    end
  end

  // =========================================
  // control register writes
  always @(posedge clk) begin
    if (reset) begin
      stopInIdle_q <= 1'b0;
      abortAll_q <= 1'b0;
      modeReq_q <= `MODE_RESET;
      capEn_q <= 1'b0;
      window_q <= 1'b0;
    end else begin
      if (wrCtrl && byteenable[1]) begin
        stopInIdle_q <= writedata[`BIT_STOP_IN_IDLE];
        modeReq_q <= writedata[`REQ_HI:`REQ_LO];
      end
      if (wrCtrl && byteenable[0]) begin
        capEn_q <= writedata[`BIT_CAPTURE];
        window_q <= writedata[`BIT_WINDOW];
      end
      // a write of one wins over the hardware clear in the same cycle
      if (wrCtrl && byteenable[1] && writedata[`BIT_ABORT_ALL]) begin
        abortAll_q <= 1'b1;
      end else if (abortAll_q && txAllAborted) begin
        abortAll_q <= 1'b0;
      end
    end
  end

  // =========================================
  // capture trigger
  always @(posedge clk) begin
    if (reset) begin
      captureTrigger <= 1'b0;
    end else begin
      captureTrigger <= rxMessageDone & capEn_q;
    end
  end

  assign abortAllTx = abortAll_q;
  assign moduleHalt = stopInIdle_q & cpuIdle;
  assign filterWindow = window_q;
  assign currentMode = curMode_q;
  assign configUnlocked = (curMode_q == `MODE_CONFIG);

  // =========================================
  // read path
  // reserved bit 11 and unimplemented bits are constant zero
  assign ctrlWord = {2'h0, stopInIdle_q, abortAll_q, 1'b0, modeReq_q,
    curMode_q, 1'b0, capEn_q, 2'h0, window_q};
  assign statWord = {12'h000, (modeReq_q != curMode_q), moduleHalt, txBusy, busIdle};

  always @(posedge clk) begin
    if (reset) begin
      readdata <= 32'h0000_0000;
    end else if (rdAccess) begin
      case (address)
        `ADDR_MODE_CTRL: readdata <= {16'h0000, ctrlWord};
        `ADDR_MODE_STAT: readdata <= {16'h0000, statWord};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// File: sim/can_bus_model.sv
// far side: bus bit stream and slow transmit buffers
// assumes the bench clock; one bit time is four clocks
`timescale 1ns/1ps
module can_bus_model (
  // clock
  input wire clk,
  // control
  input wire dominant,
  input wire abortAllTx,
  // to block
  output reg bitTick = 1'b0,
  output reg busRecessive = 1'b1,
  output reg txAllAborted = 1'b0
);
  // =====
  // bits and aborts
  reg [1:0] div_q = 2'h0;
  reg [2:0] abort_q = 3'h0;
  always @(posedge clk) begin
    div_q <= div_q + 2'h1;
    bitTick <= (div_q == 2'h3);
    busRecessive <= !dominant;
    // buffers confirm late, so the bit must stand meanwhile
    abort_q <= {abort_q[1:0], abortAllTx};
    txAllAborted <= abort_q[2];
  end
endmodule

// File: sim/can_mode_control_bench.sv
// bench for the mode control register block
// assumes the design, its defines, the bus model and checker
`timescale 1ns/1ps
`include "can_mode_control_defines.vh"
module can_mode_control_bench;
  reg clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, txBusy = 1'b0;
  reg rxMessageDone = 1'b0, cpuIdle = 1'b0, dominant = 1'b0;
  reg [3:0] address = 4'h0;
  reg [31:0] writedata = 32'h0, rd;
  wire [31:0] readdata;
  wire [2:0] currentMode;
  wire waitrequest, bitTick, busRecessive, txAllAborted, abortAllTx, moduleHalt;
  wire captureTrigger, filterWindow, configUnlocked;
  integer err_count = 0, check_count = 0, i, n;
  can_mode_control #(.IDLE_BITS(2)) DUT (.clk, .reset, .address, .read, .write,
    .writedata, .byteenable(4'h3), .readdata, .waitrequest, .bitTick, .busRecessive,
    .txBusy, .txAllAborted, .rxMessageDone, .cpuIdle, .abortAllTx, .moduleHalt,
    .captureTrigger, .filterWindow, .currentMode, .configUnlocked);
  can_bus_model farSide (.clk, .dominant, .abortAllTx, .bitTick, .busRecessive,
    .txAllAborted);
  // =====
  // tasks
  initial forever #25 clk = ~clk;
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= !w;
      write <= w;
      @(posedge clk);
      for (n = 0; n < 20 && waitrequest !== 1'b0; n = n + 1) @(posedge clk);
      if (waitrequest !== 1'b0) err_count = err_count + 1;
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask
  task wait_mode(input [2:0] m);
    for (n = 0; n < 60 && currentMode !== m; n = n + 1) @(posedge clk);
  endtask
  task pulse_rx(input exp);
    begin
      @(posedge clk);
      rxMessageDone <= 1'b1;
      @(posedge clk);
      rxMessageDone <= 1'b0;
      @(negedge clk);
      chk(captureTrigger, exp);
    end
  endtask
  task reset_state;
    begin
      bus(1'b0, `ADDR_MODE_CTRL, 32'h0);
      chk(rd, 32'h480);
      bus(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h0);
    end
  endtask
  task mode_sweep;
    for (i = 0; i < 8; i = i + 1) if (i != 5 && i != 6) begin
      bus(1'b1, `ADDR_MODE_CTRL, 32'hc0ff | (i << 8));
      wait_mode(i);
      bus(1'b0, `ADDR_MODE_CTRL, 32'h0);
      chk(rd, 32'h9 | (i << 8) | (i << 5));
      chk({configUnlocked, filterWindow}, {i == 4, 1'b1});
    end
  endtask
  task gate_check;
    begin
      dominant <= 1'b1;
      // let a dominant bit tick clear the idle count before the request lands
      repeat (8) @(posedge clk);
      bus(1'b1, `ADDR_MODE_CTRL, 32'h9);
      repeat (40) @(posedge clk);
      chk(currentMode, 3'h7);
      txBusy <= 1'b1;
      bus(1'b1, `ADDR_MODE_CTRL, 32'h409);
      dominant <= 1'b0;
      repeat (40) @(posedge clk);
      chk(currentMode, 3'h7);
      txBusy <= 1'b0;
      wait_mode(3'h4);
      chk(currentMode, 3'h4);
    end
  endtask
  task ctl_check;
    begin
      pulse_rx(1'b1);
      bus(1'b1, `ADDR_MODE_CTRL, 32'h3401);
      cpuIdle <= 1'b1;
      @(negedge clk);
      chk({abortAllTx, moduleHalt}, 2'h3);
      repeat (12) @(negedge clk);
      chk({abortAllTx, moduleHalt}, 2'h1);
      pulse_rx(1'b0);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    reset_state;
    mode_sweep;
    gate_check;
    ctl_check;
    tally_and_finish;
  end
  initial begin
    repeat (4000) @(posedge clk);
    err_count = err_count + 1;
    tally_and_finish;
  end
endmodule

// File: sim/can_mode_control_props.sv
// checker on the mode control block ports
// assumes it is bound into every block instance
`timescale 1ns/1ps
module can_mode_control_props (
  // clock and reset
  input wire clk,
  input wire reset,
  // engine side
  input wire txBusy,
  input wire txAllAborted,
  input wire rxMessageDone,
  input wire cpuIdle,
  // controls
  input wire abortAllTx,
  input wire moduleHalt,
  input wire captureTrigger,
  input wire [2:0] currentMode,
  input wire configUnlocked
);
  // =====
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  halt_needs_idle_a: assert property (moduleHalt |-> cpuIdle) else $error("halt");
  abort_holds_a: assert property (abortAllTx && !txAllAborted |=> abortAllTx)
    else $error("abort dropped");
  abort_clear_a: assert property ($fell(abortAllTx) |-> $past(txAllAborted))
    else $error("abort clear");
  mode_legal_a: assert property (currentMode != 3'h5 && currentMode != 3'h6)
    else $error("mode code");
  reset_config_a: assert property ($fell(reset) |-> currentMode == 3'h4)
    else $error("reset mode");
  capture_cause_a: assert property (captureTrigger |-> $past(rxMessageDone))
    else $error("capture");
  unlock_match_a: assert property (configUnlocked == (currentMode == 3'h4))
    else $error("unlock");
  config_no_tx_a: assert property ($changed(currentMode) && currentMode == 3'h4
    |-> !$past(txBusy)) else $error("config entry");
  cover property (captureTrigger);
  cover property (moduleHalt);
  cover property ($fell(abortAllTx));
endmodule
bind can_mode_control can_mode_control_props props (.clk, .reset, .txBusy, .txAllAborted,
  .rxMessageDone, .cpuIdle, .abortAllTx, .moduleHalt, .captureTrigger, .currentMode,
  .configUnlocked);
